// File: core/rcm_ring_call_trap_checker.sv
`timescale 1ns/1ps
`include "rcm_cfg.svh"

module rcm_ring_call_trap_checker
   import rcm_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   // Request from the processor
   input  wire logic                   reqValid,
   output logic                        reqReady,
   input  rcm_req_type                 req,
   // Ring to query on a validate request
   input  wire logic [`RCM_RING_W-1:0] queryRing,
   // Answer
   output logic                        doneValid,
   output logic                        granted,
   output logic                        secTrap,
   output rcm_cause_type               trapCause,
   output rcm_rights_type              rights,
   // Traps and interrupts raised elsewhere
   input  wire logic                   extTrap,
   input  wire logic                   interrupt,
   // Current ring of execution
   output logic [`RCM_RING_W-1:0]      currentRing,
   // Save area write port
   output logic                        saveValid,
   output logic [`RCM_ADDR_W-1:0]      saveAddr,
   output rcm_record_type              saveData,
   input  wire logic                   saveReady
);

   // ===============================================================
   // Types local to this module
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SAVE = 2'b10
   } rcm_state_type;

   typedef struct packed {
      rcm_state_type          state;
      logic [`RCM_RING_W-1:0] ring;
      logic                   done;
      logic                   grant;
      logic                   trap;
      rcm_cause_type          cause;
      rcm_rights_type         rights;
   } rcm_main_state_type;

   rcm_main_state_type s_q;
   rcm_main_state_type s_d;

   rcm_cause_type      checkCause;
   rcm_record_type     record;
   logic               saveStart;
   logic               saveBusy;
   logic               take;
   logic               violation;

   // ===============================================================
   // Rights of a ring against a descriptor
   function automatic rcm_rights_type rightsOf(
      input logic [`RCM_RING_W-1:0] ring,
      input rcm_desc_type           d
   );
      rcm_rights_type v;
      v.canWrite = d.permWrite && (ring <= d.writeLimit);
      v.canRead  = d.permRead  && (ring <= d.readExecLimit);
      v.canExec  = d.permExec  && (ring <= d.readExecLimit);
      v.canCall  = d.permExec  && (ring <= d.callLimit);
      rightsOf   = v;
   endfunction : rightsOf

   // ===============================================================
   // Violation checks, purely combinational on the request
   rcm_violation_check u_check (
      .req   (req),
      .cause (checkCause)
   );

   // ===============================================================
   // Save area writer; one record per security trap
   rcm_save_writer u_save (
      .clock     (clock),
      .rst_n     (rst_n),
      .start     (saveStart),
      .record    (record),
      .saveValid (saveValid),
      .saveAddr  (saveAddr),
      .saveData  (saveData),
      .saveReady (saveReady),
      .busy      (saveBusy)
   );

   // ===============================================================
   // Handshake terms
   // The request is taken only while idle; a pending save area write
   // must finish first so no trap record is ever overwritten.
   assign reqReady  = (s_q.state == ST_IDLE) && !saveBusy;
   assign take      = reqValid && reqReady;
   assign violation = take && (checkCause != RCM_C_NONE);
   assign saveStart = violation;

   // Cause record built from the taken request
   always_comb
   begin
      record.cause   = checkCause;
      record.kind    = req.kind;
      record.effRing = req.effRing;
      record.offset  = req.offset;
   end

   // ===============================================================
   // Next state
   always_comb
   begin
      s_d       = s_q;
      s_d.done  = 1'b0;
      s_d.grant = 1'b0;
      s_d.trap  = 1'b0;

      unique case (s_q.state)
         ST_IDLE:
         begin
            if (take)
            begin
               // The effective ring on the port is the value left by
               // address preparation; it is used once, here.
               s_d.done  = 1'b1;
               s_d.cause = checkCause;
               s_d.rights = '0;
               if (violation)
               begin
                  s_d.trap  = 1'b1;
                  s_d.state = ST_SAVE;
               end
               else
               begin
                  s_d.grant = 1'b1;
                  unique case (req.kind)
                     RCM_CALL:
                     begin
                        // No mapping on a call, only a new ring
                        if (req.effRing > req.desc.readExecLimit)
                           s_d.ring = req.desc.readExecLimit;
                        else
                           s_d.ring = s_q.ring;
                     end
                     RCM_RETURN:
                        s_d.ring = req.targetRing;
                     RCM_VALIDATE:
                        s_d.rights = rightsOf(queryRing,
                                              req.desc);
                     default:
                        s_d.ring = s_q.ring;
                  endcase
               end
            end
         end
         ST_SAVE:
         begin
            // Back to idle the cycle after the record is launched
            s_d.state = ST_IDLE;
         end
      endcase

      // Any trap or interrupt drops to the kernel ring and wins
      // over a ring change made by the same request.
      if (violation || extTrap || interrupt)
         s_d.ring = `RCM_KERNEL_RING;
   end

   // ===============================================================
   // State register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q        <= '0;
         s_q.state  <= ST_IDLE;
         s_q.ring   <= `RCM_RING_RST;
         s_q.cause  <= RCM_C_NONE;
      end
      else
         s_q <= s_d;
   end

   // ===============================================================
   // Outputs, all from the state register
   assign doneValid   = s_q.done;
   assign granted     = s_q.grant;
   assign secTrap     = s_q.trap;
   assign trapCause   = s_q.cause;
   assign rights      = s_q.rights;
   assign currentRing = s_q.ring;

endmodule : rcm_ring_call_trap_checker

// File: core/rcm_cfg.svh
`ifndef RCM_CFG_SVH
`define RCM_CFG_SVH

// ==================================================================
// Widths
`define RCM_RING_W      3
`define RCM_OFS_W       12
`define RCM_ADDR_W      16

// ==================================================================
// Reset values, fixed rings and the call entry offset
`define RCM_RING_RST    3'h0
`define RCM_KERNEL_RING 3'h0
`define RCM_ENTRY_OFS   12'h000

// ==================================================================
// Security trap save area base address
`define RCM_SAVE_ADDR   16'h0040

`endif

// File: core/rcm_pkg.sv
`include "rcm_cfg.svh"

package rcm_pkg;

   // ===============================================================
   // Request kinds
   typedef enum logic [3:0] {
      RCM_MEM_READ  = 4'h0,
      RCM_MEM_WRITE = 4'h1,
      RCM_MEM_FETCH = 4'h2,
      RCM_DEV_READ  = 4'h3,
      RCM_DEV_WRITE = 4'h4,
      RCM_DEV_CTRL  = 4'h5,
      RCM_CALL      = 4'h6,
      RCM_RETURN    = 4'h7,
      RCM_VALIDATE  = 4'h8
   } rcm_kind_type;

   // ===============================================================
   // Encoded trap causes, lower code value is not priority
   typedef enum logic [3:0] {
      RCM_C_NONE      = 4'h0,
      RCM_C_DIRECTED  = 4'h1,
      RCM_C_LIMIT     = 4'h2,
      RCM_C_WRITE     = 4'h3,
      RCM_C_READ      = 4'h4,
      RCM_C_EXEC      = 4'h5,
      RCM_C_NO_ACCESS = 4'h6,
      RCM_C_NO_DIRECT = 4'h7,
      RCM_C_LEVEL1    = 4'h8,
      RCM_C_CALL      = 4'h9,
      RCM_C_ENTRY     = 4'hA,
      RCM_C_RETURN    = 4'hB,
      RCM_C_CONTROL   = 4'hC
   } rcm_cause_type;

   // ===============================================================
   // Descriptor ring brackets and permits
   typedef struct packed {
      logic [`RCM_RING_W-1:0] writeLimit;
      logic [`RCM_RING_W-1:0] readExecLimit;
      logic [`RCM_RING_W-1:0] callLimit;
      logic                   permRead;
      logic                   permWrite;
      logic                   permExec;
   } rcm_desc_type;

   // Descriptor walk outcome reported by the address preparation
   typedef struct packed {
      logic directed;
      logic limitViol;
      logic accessMissing;
      logic allIndirect;
      logic level1Direct;
      logic viaIndirect;
   } rcm_fault_type;

   typedef struct packed {
      rcm_kind_type           kind;
      logic [`RCM_RING_W-1:0] effRing;
      logic [`RCM_RING_W-1:0] targetRing;
      logic [`RCM_OFS_W-1:0]  offset;
      logic                   handlerEntry;
      rcm_desc_type           desc;
      rcm_fault_type          faults;
   } rcm_req_type;

   typedef struct packed {
      logic canRead;
      logic canWrite;
      logic canExec;
      logic canCall;
   } rcm_rights_type;

   // Cause record written to the save area
   typedef struct packed {
      rcm_cause_type          cause;
      rcm_kind_type           kind;
      logic [`RCM_RING_W-1:0] effRing;
      logic [`RCM_OFS_W-1:0]  offset;
   } rcm_record_type;

endpackage : rcm_pkg

// File: core/rcm_violation_check.sv
`timescale 1ns/1ps
`include "rcm_cfg.svh"

module rcm_violation_check
   import rcm_pkg::*;
(
   input  rcm_req_type   req,
   output rcm_cause_type cause
);

   // ===============================================================
   // Ring test shared by all bracket checks
   function automatic logic above(
      input logic [`RCM_RING_W-1:0] ring,
      input logic [`RCM_RING_W-1:0] lim
   );
      above = ring > lim;
   endfunction : above

   // ===============================================================
   // First failing condition wins; one cause per access
   always_comb
   begin
      logic [`RCM_RING_W-1:0] r;
      logic                   isDev;
      logic                   isDesc;
      rcm_desc_type           d;
      r      = req.effRing;
      d      = req.desc;
      isDev  = req.kind inside {RCM_DEV_READ, RCM_DEV_WRITE,
                                RCM_DEV_CTRL};
      isDesc = !(req.kind inside {RCM_RETURN, RCM_VALIDATE});
      cause  = RCM_C_NONE;
      // Handler entry fetches run at kernel privilege
      if (req.handlerEntry)
         r = `RCM_KERNEL_RING;
      if (isDesc && req.faults.directed)
         cause = RCM_C_DIRECTED;
      else if (isDesc && req.faults.limitViol
               && (!isDev || req.faults.viaIndirect))
         cause = RCM_C_LIMIT;
      else if (isDesc && req.faults.accessMissing)
         cause = RCM_C_NO_ACCESS;
      else if (isDesc && req.faults.allIndirect)
         cause = RCM_C_NO_DIRECT;
      else if (isDesc && req.faults.level1Direct)
         cause = RCM_C_LEVEL1;
      else
      begin
         unique case (req.kind)
            RCM_MEM_WRITE, RCM_DEV_WRITE:
               if (above(r, d.writeLimit) || !d.permWrite)
                  cause = RCM_C_WRITE;
            RCM_MEM_READ, RCM_DEV_READ:
               if (above(r, d.readExecLimit) || !d.permRead)
                  cause = RCM_C_READ;
            RCM_MEM_FETCH:
               if (above(r, d.readExecLimit) || !d.permExec)
                  cause = RCM_C_EXEC;
            RCM_DEV_CTRL:
               if (above(r, d.callLimit) || !d.permExec)
                  cause = RCM_C_CONTROL;
            RCM_CALL:
               // Even from inside the execute bracket a call must enter at the gate
               if (above(r, d.callLimit))
                  cause = RCM_C_CALL;
               else if (!d.permExec)
                  cause = RCM_C_EXEC;
               else if (req.offset != `RCM_ENTRY_OFS)
                  cause = RCM_C_ENTRY;
            RCM_RETURN:
               if (above(r, req.targetRing))
                  cause = RCM_C_RETURN;
            default:
               cause = RCM_C_NONE;
         endcase
      end
   end

endmodule : rcm_violation_check

// File: core/rcm_save_writer.sv
`timescale 1ns/1ps
`include "rcm_cfg.svh"

module rcm_save_writer
   import rcm_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic                   start,
   input  rcm_record_type              record,
   output logic                        saveValid,
   output logic [`RCM_ADDR_W-1:0]      saveAddr,
   output rcm_record_type              saveData,
   input  wire logic                   saveReady,
   output logic                        busy
);

   typedef struct packed {
      logic           valid;
      rcm_record_type data;
   } rcm_sw_state_type;

   rcm_sw_state_type s_q;
   rcm_sw_state_type s_d;

   // ===============================================================
   // Hold the write until memory accepts it
   always_comb
   begin
      s_d = s_q;
      if (s_q.valid && saveReady)
         s_d.valid = 1'b0;
      if (start && !s_q.valid)
      begin
         s_d.valid = 1'b1;
         s_d.data  = record;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign saveValid = s_q.valid;
   assign saveAddr  = `RCM_SAVE_ADDR; // Dedicated security save area
   assign saveData  = s_q.data;
   assign busy      = s_q.valid;

endmodule : rcm_save_writer

// File: verification/rcm_checker_assertions.sv
`timescale 1ns/1ps
`include "rcm_cfg.svh"

module rcm_checker
   import rcm_pkg::*;
(
   input wire logic                   clock,
   input wire logic                   rst_n,
   input wire logic                   reqValid,
   input wire logic                   reqReady,
   input rcm_req_type                 req,
   input wire logic                   doneValid,
   input wire logic                   granted,
   input wire logic                   secTrap,
   input rcm_cause_type               trapCause,
   input wire logic                   extTrap,
   input wire logic                   interrupt,
   input wire logic [`RCM_RING_W-1:0] currentRing,
   input wire logic                   saveValid,
   input wire logic [`RCM_ADDR_W-1:0] saveAddr,
   input rcm_record_type              saveData,
   input wire logic                   saveReady
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // ===========================================================
   // Steps of a request
   sequence s_take;
      reqValid && reqReady;
   endsequence
   // No structural fault, handler entry or outside event muddies it
   sequence s_clean;
      req.faults == '0 && !req.handlerEntry && !extTrap && !interrupt;
   endsequence

   // ===========================================================
   // Answer and trap properties
   property p_answer;
      s_take |=> doneValid;
   endproperty
   a_answer: assert property (p_answer)
      else $error("taken request got no answer");
   property p_single;
      doneValid |-> (granted ^ secTrap)
         && (granted == (trapCause == RCM_C_NONE));
   endproperty
   a_single: assert property (p_single)
      else $error("answer is not one of grant or trap");
   property p_trap_ring;
      secTrap |-> currentRing == `RCM_KERNEL_RING;
   endproperty
   a_trap_ring: assert property (p_trap_ring)
      else $error("ring not zero on trap");
   property p_event_ring;
      (extTrap || interrupt) |=> currentRing == `RCM_KERNEL_RING;
   endproperty
   a_event_ring: assert property (p_event_ring)
      else $error("ring not zero after outside event");
   property p_save_start;
      secTrap |-> saveValid && !reqReady && saveData.cause == trapCause;
   endproperty
   a_save_start: assert property (p_save_start)
      else $error("trap did not start cause save");
   property p_save_hold;
      saveValid && !saveReady |=> saveValid && $stable(saveData);
   endproperty
   a_save_hold: assert property (p_save_hold)
      else $error("save write dropped or changed");
   property p_save_addr;
      saveValid |-> saveAddr == `RCM_SAVE_ADDR;
   endproperty
   a_save_addr: assert property (p_save_addr)
      else $error("save write outside trap save area");
   property p_call_deny;
      s_take ##0 s_clean ##0 (req.kind == RCM_CALL
         && req.effRing > req.desc.callLimit)
         |=> secTrap && trapCause == RCM_C_CALL;
   endproperty
   a_call_deny: assert property (p_call_deny)
      else $error("call above call limit not trapped");
   property p_call_load;
      s_take ##0 s_clean ##0 (req.kind == RCM_CALL
         && req.offset == `RCM_ENTRY_OFS && req.desc.permExec
         && req.effRing > req.desc.readExecLimit
         && req.effRing <= req.desc.callLimit)
         |=> granted && currentRing == $past(req.desc.readExecLimit);
   endproperty
   a_call_load: assert property (p_call_load)
      else $error("gate call did not load read limit");
   property p_return;
      s_take ##0 s_clean ##0 (req.kind == RCM_RETURN
         && req.effRing <= req.targetRing)
         |=> granted && currentRing == $past(req.targetRing);
   endproperty
   a_return: assert property (p_return)
      else $error("outward return did not load target");
endmodule : rcm_checker

bind rcm_ring_call_trap_checker rcm_checker chk_u (
   .clock(clock), .rst_n(rst_n), .reqValid(reqValid),
   .reqReady(reqReady), .req(req), .doneValid(doneValid),
   .granted(granted), .secTrap(secTrap), .trapCause(trapCause),
   .extTrap(extTrap), .interrupt(interrupt),
   .currentRing(currentRing), .saveValid(saveValid),
   .saveAddr(saveAddr), .saveData(saveData), .saveReady(saveReady)
);

// File: verification/rcm_save_mem.sv
`timescale 1ns/1ps

module rcm_save_mem
   import rcm_pkg::*;
(
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       saveValid,
   input rcm_record_type  saveData,
   input wire logic [3:0] stall,
   output logic           saveReady,
   output rcm_record_type lastRec
);
   logic [3:0] waitCnt;

   // ===========================================================
   // Memory side: accepts a save word after a chosen stall
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         waitCnt   <= 4'h0;
         saveReady <= 1'b0;
         lastRec   <= '0;
      end
      else
      begin
         saveReady <= 1'b0;
         if (saveValid && saveReady)
         begin
            lastRec <= saveData;
            waitCnt <= 4'h0;
         end
         else if (saveValid && waitCnt >= stall)
            saveReady <= 1'b1;
         else if (saveValid)
            waitCnt <= waitCnt + 4'h1;
      end
   end
endmodule : rcm_save_mem

// File: verification/tb_top.sv
`timescale 1ns/1ps
`include "rcm_cfg.svh"

module tb_top;
   import rcm_pkg::*;
   logic                   clock, rst_n, reqValid, reqReady;
   logic                   doneValid, granted, secTrap;
   logic                   extTrap, interrupt, saveValid, saveReady;
   rcm_req_type            req;
   logic [`RCM_RING_W-1:0] queryRing, currentRing;
   rcm_cause_type          trapCause;
   rcm_rights_type         rights;
   logic [`RCM_ADDR_W-1:0] saveAddr;
   rcm_record_type         saveData, lastRec;
   logic [3:0]             stall;
   rcm_desc_type           dG;
   rcm_fault_type          fl[5];
   rcm_cause_type          cl[5];
   int                     errorCnt, numChecks, cycles;

   rcm_ring_call_trap_checker dut_u (.clock(clock), .rst_n(rst_n),
      .reqValid(reqValid), .reqReady(reqReady), .req(req),
      .queryRing(queryRing), .doneValid(doneValid), .granted(granted),
      .secTrap(secTrap), .trapCause(trapCause), .rights(rights),
      .extTrap(extTrap), .interrupt(interrupt),
      .currentRing(currentRing), .saveValid(saveValid),
      .saveAddr(saveAddr), .saveData(saveData), .saveReady(saveReady));
   rcm_save_mem mem_u (.clock(clock), .rst_n(rst_n),
      .saveValid(saveValid), .saveData(saveData), .stall(stall),
      .saveReady(saveReady), .lastRec(lastRec));

   // ===========================================================
   // Clock, and a cycle ceiling so a hang still ends the run
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errorCnt++;
         finalReport();
      end
   end

   // ===========================================================
   // Helpers
   task chk(input string nm, input logic [15:0] seen, exp);
      numChecks++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("BAD %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   function rcm_desc_type dsc(input logic [2:0] w, r, c, p);
      return {w, r, c, p};
   endfunction : dsc

   // One request; a trap also waits for its save word to land
   task go(input rcm_kind_type k, input logic [2:0] eff, tgt,
           input logic [11:0] ofs, input rcm_desc_type d,
           input rcm_fault_type f, input logic h,
           input rcm_cause_type ec, input logic [2:0] er);
      int n;
      @(posedge clock);
      req      <= {k, eff, tgt, ofs, h, d, f};
      reqValid <= 1'b1;
      n = 0;
      do
      begin
         @(negedge clock);
         n++;
      end while (reqReady !== 1'b1 && n < 40);
      @(posedge clock);
      reqValid <= 1'b0;
      @(negedge clock);
      chk("done", doneValid, 1'b1);
      chk("cause", trapCause, ec);
      chk("trap", secTrap, ec != RCM_C_NONE);
      chk("grant", granted, ec == RCM_C_NONE);
      chk("ring", currentRing, er);
      if (ec != RCM_C_NONE)
      begin
         for (n = 0; n < 40 && saveValid !== 1'b0; n++)
            @(negedge clock);
         chk("savedone", saveValid, 1'b0);
         chk("saved", lastRec.cause, ec);
      end
   endtask : go

   task finalReport();
      if (errorCnt == 0 && numChecks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finalReport

   // ===========================================================
   // Main sequence
   initial
   begin
      {rst_n, reqValid, extTrap, interrupt} = 4'h0;
      req = '0;
      queryRing = 3'h0;
      stall = 4'h0;
      dG = dsc(3'h1, 3'h2, 3'h4, 3'h7);
      fl = '{6'h30, 6'h10, 6'h08, 6'h04, 6'h02};
      cl = '{RCM_C_DIRECTED, RCM_C_LIMIT, RCM_C_NO_ACCESS,
             RCM_C_NO_DIRECT, RCM_C_LEVEL1};
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      go(RCM_RETURN, 0, 5, 0, dG, 0, 0, RCM_C_NONE, 5);
      go(RCM_CALL, 3, 0, 0, dG, 0, 0, RCM_C_NONE, 2);
      go(RCM_CALL, 1, 0, 0, dG, 0, 0, RCM_C_NONE, 2);
      // Each outside event kind drops a raised ring
      for (int i = 0; i < 2; i++)
      begin
         go(RCM_RETURN, 2, 6, 0, dG, 0, 0, RCM_C_NONE, 6);
         @(posedge clock);
         {extTrap, interrupt} <= i ? 2'h2 : 2'h1;
         @(posedge clock);
         {extTrap, interrupt} <= 2'h0;
         @(negedge clock);
         chk("evring", currentRing, 0);
      end
      go(RCM_CALL, 2, 0, 0, dsc(1, 2, 2, 7), 0, 0, RCM_C_NONE, 0);
      // Raise the ring first so the trap really has to force it down
      go(RCM_RETURN, 0, 3, 0, dG, 0, 0, RCM_C_NONE, 3);
      stall <= 4'h5;
      go(RCM_CALL, 5, 0, 0, dG, 0, 0, RCM_C_CALL, 0);
      go(RCM_CALL, 1, 0, 1, dG, 0, 0, RCM_C_ENTRY, 0);
      go(RCM_CALL, 1, 0, 0, dsc(1, 2, 4, 6), 0, 0, RCM_C_EXEC, 0);
      go(RCM_RETURN, 3, 2, 0, dG, 0, 0, RCM_C_RETURN, 0);
      stall <= 4'h0;
      go(RCM_MEM_WRITE, 2, 0, 0, dG, 0, 0, RCM_C_WRITE, 0);
      go(RCM_MEM_WRITE, 0, 0, 0, dsc(1, 2, 4, 5), 0, 0, RCM_C_WRITE, 0);
      go(RCM_MEM_READ, 3, 0, 0, dG, 0, 0, RCM_C_READ, 0);
      go(RCM_MEM_READ, 0, 0, 0, dsc(1, 2, 4, 3), 0, 0, RCM_C_READ, 0);
      go(RCM_MEM_FETCH, 3, 0, 0, dG, 0, 0, RCM_C_EXEC, 0);
      go(RCM_MEM_FETCH, 0, 0, 0, dsc(1, 2, 4, 6), 0, 0, RCM_C_EXEC, 0);
      for (int i = 0; i < 5; i++)
         go(RCM_MEM_READ, 3, 0, 0, dG, fl[i], 0, cl[i], 0);
      go(RCM_DEV_CTRL, 5, 0, 0, dG, 0, 0, RCM_C_CONTROL, 0);
      go(RCM_DEV_CTRL, 0, 0, 0, dsc(1, 2, 4, 6), 0, 0, RCM_C_CONTROL, 0);
      go(RCM_DEV_WRITE, 2, 0, 0, dG, 0, 0, RCM_C_WRITE, 0);
      go(RCM_DEV_READ, 3, 0, 0, dG, 0, 0, RCM_C_READ, 0);
      go(RCM_DEV_READ, 0, 0, 0, dG, 6'h10, 0, RCM_C_NONE, 0);
      go(RCM_DEV_READ, 0, 0, 0, dG, 6'h11, 0, RCM_C_LIMIT, 0);
      go(RCM_MEM_FETCH, 7, 0, 0, dsc(0, 0, 0, 7), 0, 1, RCM_C_NONE, 0);
      @(posedge clock);
      queryRing <= 3'h1;
      go(RCM_VALIDATE, 0, 0, 0, dG, 0, 0, RCM_C_NONE, 0);
      chk("rights", rights, 4'hF);
      @(posedge clock);
      queryRing <= 3'h5;
      go(RCM_VALIDATE, 7, 0, 0, dG, 0, 0, RCM_C_NONE, 0);
      chk("rights", rights, 4'h0);
      finalReport();
   end
endmodule : tb_top
